// ### core/tas_cmp_if.sv
`timescale 1ns/1ps
interface tas_cmp_if;
  logic signed [15:0] temp;
  logic signed [15:0] setpoint;
  logic        [7:0]  hyst;
  logic               above;
  logic               below;
  logic               hyst_hit;
  modport cmp (input temp, input setpoint, input hyst, output above, output below,
               output hyst_hit);
  modport user (output temp, output setpoint, output hyst, input above, input below,
                input hyst_hit);
endinterface : tas_cmp_if

// ### core/tas_fault_q.sv
`timescale 1ns/1ps
module tas_fault_q (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       sample,
  input  wire logic       fault,
  input  wire logic [1:0] depth,
  output logic            alarm
);
  import tas_pkg::*;
  logic [1:0] cnt_reg;
  logic [1:0] cnt_next;
  logic       alarm_reg;
  logic       alarm_next;
  logic [1:0] need;
  always_comb begin
    unique case (depth)
      FQ_ONE:   need = 2'h0;
      FQ_TWO:   need = 2'h1;
      FQ_THREE: need = 2'h2;
      default:  need = 2'h2; // Unlisted code treated as deepest filter
    endcase
    cnt_next   = cnt_reg;
    alarm_next = alarm_reg;
    if (sample) begin
      if (!fault) begin
        cnt_next   = 2'h0;
        alarm_next = 1'b0;
      end else if (cnt_reg >= need) begin
        alarm_next = 1'b1; // RULE11 RULE12
      end else begin
        cnt_next = cnt_reg + 2'h1;
      end
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_reg   <= 2'h0;
      alarm_reg <= 1'b0;
    end else begin
      cnt_reg   <= cnt_next;
      alarm_reg <= alarm_next;
    end
  end
  assign alarm = alarm_reg;
endmodule : tas_fault_q

// ### core/tas_limit_cmp.sv
`timescale 1ns/1ps
module tas_limit_cmp #(
  parameter bit LOW_SIDE = 1'b0
) (
  tas_cmp_if.cmp c
);
  import tas_pkg::*;
  logic signed [17:0] t18;
  logic signed [17:0] s18;
  logic signed [17:0] h18;
  always_comb begin
    t18     = 18'(c.temp);
    s18     = 18'(c.setpoint);
    h18     = 18'(signed'({1'b0, c.hyst}));
    c.above = t18 > s18;
    c.below = t18 < s18;
    // Low limit releases above setpoint plus hysteresis, others below minus
    c.hyst_hit = LOW_SIDE ? (t18 > s18 + h18) : (t18 < s18 - h18);
  end
endmodule : tas_limit_cmp

// ### core/tas_pkg.sv
package tas_pkg;
  localparam logic [7:0] STATUS_ADDR      = 8'h02;
  localparam logic [7:0] CONFIG_ADDR      = 8'h03;
  localparam logic [7:0] TEMP_MSB_ADDR    = 8'h00;
  localparam logic [7:0] TEMP_LSB_ADDR    = 8'h01;
  localparam int         LOW_FLAG_BIT     = 4;
  localparam int         HIGH_FLAG_BIT    = 5;
  localparam int         CRIT_FLAG_BIT    = 6;
  localparam int         RDY_BIT          = 7;
  localparam int         FQ_LSB           = 0;
  localparam int         FQ_MSB           = 1;
  localparam int         MODE_LSB         = 5;
  localparam int         MODE_MSB         = 6;
  localparam logic [7:0] CONFIG_RESET     = 8'h00;
  localparam logic       RDY_RESET        = 1'b1;
  localparam logic [1:0] MODE_ONE_SHOT    = 2'h1;
  localparam logic [1:0] MODE_ONE_SAMPLE_PER_SECOND = 2'h2;
  localparam logic [1:0] FQ_ONE           = 2'h0;
  localparam logic [1:0] FQ_TWO           = 2'h1;
  localparam logic [1:0] FQ_THREE         = 2'h2;
endpackage : tas_pkg

// ### core/tas_status_cfg.sv
`timescale 1ns/1ps
// Function
// (RULE1) Set low flag below low setpoint
// (RULE2) Clear low flag: status read or recovery
// (RULE3) Set high flag above high setpoint
// (RULE4) Clear high flag: status read or recovery
// (RULE5) Set critical flag above critical setpoint
// (RULE6) Clear critical flag: status read or recovery
// (RULE7) Ready bit low when result stored
// (RULE8) Ready high on temperature read, reset
// (RULE9) Mode write clears ready in slow modes
// (RULE10) Eight-bit read/write configuration register
// (RULE11) Fault queue gates alarm and critical pins
// (RULE12) Queue codes: one, two, three faults
// (RULE13) Compare per result; status low nibble zero
module tas_status_cfg (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        result_valid,
  input  wire logic [15:0] temp_value,
  input  wire logic [15:0] low_limit_setpoint,
  input  wire logic [15:0] high_limit_setpoint,
  input  wire logic [15:0] critical_limit_setpoint,
  input  wire logic [7:0]  limit_hysteresis,
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_rd,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic      [7:0]  config_out,
  output logic             alarm_out,
  output logic             critical_output_pin
);
  import tas_pkg::*;

  // Next value of one limit flag; a fresh result that trips or recovers outranks a status read
  function automatic logic flag_update(
    input logic cur,
    input logic rd_clear,
    input logic sample,
    input logic trip,
    input logic recover
  );
    logic nxt;
    nxt = cur;
    if (rd_clear) begin
      nxt = 1'b0;
    end
    if (sample) begin
      if (trip) begin
        nxt = 1'b1;
      end else if (recover) begin
        nxt = 1'b0;
      end
    end
    return nxt;
  endfunction : flag_update

  function automatic logic addr_hit(
    input logic [7:0] addr,
    input logic [7:0] target
  );
    return addr == target;
  endfunction : addr_hit

  // Only these two modes re-arm ready on a configuration write
  function automatic logic mode_is_slow(
    input logic [7:0] cfg
  );
    logic slow;
    unique case (cfg[MODE_MSB:MODE_LSB])
      MODE_ONE_SHOT:              slow = 1'b1;
      MODE_ONE_SAMPLE_PER_SECOND: slow = 1'b1;
      default:                    slow = 1'b0;
    endcase
    return slow;
  endfunction : mode_is_slow

  function automatic logic [7:0] pack_status(
    input logic low,
    input logic high,
    input logic crit,
    input logic rdy_n
  );
    logic [7:0] val;
    val                = 8'h00; // RULE13
    val[LOW_FLAG_BIT]  = low;
    val[HIGH_FLAG_BIT] = high;
    val[CRIT_FLAG_BIT] = crit;
    val[RDY_BIT]       = rdy_n;
    return val;
  endfunction : pack_status

  // Temperature bytes are kept outside this block and read as zero here
  function automatic logic [7:0] read_mux(
    input logic [7:0] addr,
    input logic [7:0] status,
    input logic [7:0] cfg
  );
    logic [7:0] val;
    val = 8'h00;
    if (addr_hit(addr, STATUS_ADDR)) begin
      val = status;
    end else if (addr_hit(addr, CONFIG_ADDR)) begin
      val = cfg; // RULE10
    end
    return val;
  endfunction : read_mux

  logic       low_reg;
  logic       low_next;
  logic       high_reg;
  logic       high_next;
  logic       crit_reg;
  logic       crit_next;
  logic       rdy_n_reg;
  logic       rdy_n_next;
  logic [7:0] cfg_reg;
  logic [7:0] cfg_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic       rd_status;
  logic       rd_temp;
  logic       wr_cfg;
  logic       slow_mode;
  logic [7:0] status_val;
  logic       limit_fault;
  logic       crit_fault;
  logic [1:0] fq_depth;

  tas_cmp_if lo_if ();
  tas_cmp_if hi_if ();
  tas_cmp_if cr_if ();

  assign lo_if.temp     = temp_value;
  assign lo_if.setpoint = low_limit_setpoint;
  assign lo_if.hyst     = limit_hysteresis;
  assign hi_if.temp     = temp_value;
  assign hi_if.setpoint = high_limit_setpoint;
  assign hi_if.hyst     = limit_hysteresis;
  assign cr_if.temp     = temp_value;
  assign cr_if.setpoint = critical_limit_setpoint;
  assign cr_if.hyst     = limit_hysteresis;

  tas_limit_cmp #(.LOW_SIDE(1'b1)) u_lo (.c(lo_if));
  tas_limit_cmp #(.LOW_SIDE(1'b0)) u_hi (.c(hi_if));
  tas_limit_cmp #(.LOW_SIDE(1'b0)) u_cr (.c(cr_if));

  // Undertemperature and overtemperature results share one alarm filter
  always_comb begin
    limit_fault = lo_if.below | hi_if.above;
    crit_fault  = cr_if.above;
    fq_depth    = cfg_reg[FQ_MSB:FQ_LSB];
  end

  tas_fault_q u_fq_alarm (
    .clk   (clk),
    .rst   (rst),
    .sample(result_valid),
    .fault (limit_fault),
    .depth (fq_depth),
    .alarm (alarm_out)
  );
  // Critical pin is filtered by the same queue depth as the alarm
  tas_fault_q u_fq_crit (
    .clk   (clk),
    .rst   (rst),
    .sample(result_valid),
    .fault (crit_fault),
    .depth (fq_depth),
    .alarm (critical_output_pin)
  );

  // Access decode shared by all register groups
  always_comb begin
    rd_status  = reg_rd && addr_hit(reg_addr, STATUS_ADDR);
    rd_temp    = reg_rd && (addr_hit(reg_addr, TEMP_MSB_ADDR) ||
                            addr_hit(reg_addr, TEMP_LSB_ADDR));
    wr_cfg     = reg_wr && addr_hit(reg_addr, CONFIG_ADDR);
    slow_mode  = mode_is_slow(cfg_reg);
    status_val = pack_status(
      low_reg,
      high_reg,
      crit_reg,
      rdy_n_reg
    );
  end

  // A flag is judged only in the cycle a new result is stored
  always_comb begin
    low_next = flag_update(
      low_reg,
      rd_status,
      result_valid,
      lo_if.below,
      lo_if.hyst_hit
    ); // RULE1 RULE2 RULE13
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      low_reg <= 1'b0;
    end else begin
      low_reg <= low_next;
    end
  end

  always_comb begin
    high_next = flag_update(
      high_reg,
      rd_status,
      result_valid,
      hi_if.above,
      hi_if.hyst_hit
    ); // RULE3 RULE4 RULE13
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      high_reg <= 1'b0;
    end else begin
      high_reg <= high_next;
    end
  end

  always_comb begin
    crit_next = flag_update(
      crit_reg,
      rd_status,
      result_valid,
      cr_if.above,
      cr_if.hyst_hit
    ); // RULE5 RULE6 RULE13
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      crit_reg <= 1'b0;
    end else begin
      crit_reg <= crit_next;
    end
  end

  // Ready is active low; a new result outranks any re-arm in the same cycle
  always_comb begin
    rdy_n_next = rdy_n_reg;
    if (rd_temp) begin
      rdy_n_next = 1'b1; // RULE8
    end
    if (wr_cfg && slow_mode) begin
      rdy_n_next = 1'b1; // RULE9
    end
    if (result_valid) begin
      rdy_n_next = 1'b0; // RULE7
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdy_n_reg <= RDY_RESET; // RULE8
    end else begin
      rdy_n_reg <= rdy_n_next;
    end
  end

  // Stored whole; bits other than the fault queue and mode fields only read back here
  always_comb begin
    cfg_next = cfg_reg;
    if (wr_cfg) begin
      cfg_next = reg_wdata; // RULE10
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      cfg_reg <= CONFIG_RESET; // RULE11
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Read data holds until the next read, so a late host fetch still sees it
  always_comb begin
    rdata_next = rdata_reg;
    if (reg_rd) begin
      rdata_next = read_mux(
        reg_addr,
        status_val,
        cfg_reg
      );
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata  = rdata_reg;
  assign config_out = cfg_reg;
endmodule : tas_status_cfg

// ### tb/tas_host_model.sv
`timescale 1ns/1ps
module tas_host_model (
  input  wire logic [7:0] reg_rdata,
  input  wire logic       clk,
  output logic      [7:0] reg_addr = 8'h00,
  output logic            reg_rd = 1'b0,
  output logic            reg_wr = 1'b0,
  output logic      [7:0] reg_wdata = 8'h00
);
  task automatic xfer(input logic [7:0] a, input logic w, input logic [7:0] d,
                      output logic [7:0] q);
    @(posedge clk) #1;
    reg_addr = a;
    reg_wdata = d;
    reg_rd = !w;
    reg_wr = w;
    @(posedge clk) #1;
    reg_rd = 1'b0;
    reg_wr = 1'b0;
    // Idle lines show inverted values so stale data cannot pass
    reg_addr = ~a;
    reg_wdata = ~d;
    q = reg_rdata;
  endtask : xfer
endmodule : tas_host_model

// ### tb/tas_status_cfg_monitor.sv
`timescale 1ns/1ps
module tas_status_cfg_monitor (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        result_valid,
  input wire logic [15:0] temp_value,
  input wire logic [15:0] critical_limit_setpoint,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [7:0]  reg_rdata,
  input wire logic [7:0]  config_out,
  input wire logic        critical_output_pin
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  wire hot = $signed(temp_value) > $signed(critical_limit_setpoint);
  sequence st_rd;
    reg_rd && reg_addr == 8'h02 && !result_valid;
  endsequence
  a_nibble_zero: assert property (st_rd |=> reg_rdata[3:0] == 4'h0)
    else $error("status low bits set");
  a_read_clears: assert property (
    st_rd ##1 !result_valid ##1 st_rd |=> reg_rdata[6:4] == 3'h0)
    else $error("flags survived read");
  a_ready_low: assert property (
    result_valid && !reg_wr ##1 (!reg_rd && !reg_wr)[*4] ##1 st_rd |=> !reg_rdata[7])
    else $error("ready not low");
  a_ready_high: assert property (
    reg_rd && reg_addr < 8'h02 && !result_valid ##1 !result_valid ##1 st_rd |=> reg_rdata[7])
    else $error("ready not high");
  a_cfg_write: assert property (
    reg_wr && reg_addr == 8'h03 |=> config_out == $past(reg_wdata))
    else $error("config not written");
  a_cfg_read: assert property (
    reg_rd && !reg_wr && reg_addr == 8'h03 |=> reg_rdata == config_out)
    else $error("config readback wrong");
  a_fq_one: assert property (
    config_out[1:0] == 2'h0 && result_valid && hot |-> ##[1:3] critical_output_pin)
    else $error("pin not raised");
  a_no_fault: assert property (
    result_valid && !hot |-> ##[1:3] !critical_output_pin)
    else $error("pin not dropped");
  cover property (st_rd ##1 !result_valid ##1 st_rd);
  cover property (critical_output_pin);
  cover property (reg_wr && reg_addr == 8'h03);
endmodule : tas_status_cfg_monitor

bind tas_status_cfg tas_status_cfg_monitor u_mon (.clk(clk), .rst(rst),
  .result_valid(result_valid), .temp_value(temp_value),
  .critical_limit_setpoint(critical_limit_setpoint), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .config_out(config_out), .critical_output_pin(critical_output_pin));

// ### tb/test_temp_alarm_status_config.sv
`timescale 1ns/1ps
module test_temp_alarm_status_config;
  import tas_pkg::*;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        rv = 1'b0;
  logic [15:0] tv = 16'h0000;
  logic [7:0]  addr, wd, rdat, cfg, q;
  logic        rd, wr, alarm, crit;
  int          mismatches = 0;
  int          compares = 0;
  always #20 clk = ~clk;
  tas_host_model host (.clk(clk), .reg_rdata(rdat), .reg_addr(addr), .reg_rd(rd),
    .reg_wr(wr), .reg_wdata(wd));
  tas_status_cfg dut (.clk(clk), .rst(rst), .result_valid(rv), .temp_value(tv),
    .low_limit_setpoint(16'h0064), .high_limit_setpoint(16'h00C8),
    .critical_limit_setpoint(16'h012C), .limit_hysteresis(8'h05), .reg_addr(addr),
    .reg_rd(rd), .reg_wr(wr), .reg_wdata(wd), .reg_rdata(rdat), .config_out(cfg),
    .alarm_out(alarm), .critical_output_pin(crit));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] exp);
    host.xfer(a, 1'b0, 8'h00, q);
    chk(q, exp);
  endtask : rc
  task automatic conv(input logic [15:0] t);
    @(posedge clk) #1;
    tv = t;
    rv = 1'b1;
    @(posedge clk) #1;
    rv = 1'b0;
    tv = ~t;
    repeat (3) @(posedge clk);
  endtask : conv
  task automatic tally_and_finish;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    rc(STATUS_ADDR, 8'h80);
    rc(CONFIG_ADDR, CONFIG_RESET);
    host.xfer(CONFIG_ADDR, 1'b1, 8'h5C, q);
    rc(CONFIG_ADDR, 8'h5C);
    host.xfer(STATUS_ADDR, 1'b1, 8'hFF, q);
    rc(STATUS_ADDR, 8'h80);
    rc(8'h0B, 8'h00);
    conv(16'h0032);
    rc(STATUS_ADDR, 8'h10);
    rc(STATUS_ADDR, 8'h00);
    conv(16'h0032);
    conv(16'h0069);
    rc(STATUS_ADDR, 8'h10);
    conv(16'h0032);
    conv(16'h006A);
    rc(STATUS_ADDR, 8'h00);
    conv(16'h00FA);
    chk({7'h00, alarm}, 8'h01);
    rc(STATUS_ADDR, 8'h20);
    conv(16'h00FA);
    conv(16'h00C3);
    rc(STATUS_ADDR, 8'h20);
    conv(16'h00FA);
    conv(16'h00C2);
    rc(STATUS_ADDR, 8'h00);
    conv(16'h015E);
    rc(STATUS_ADDR, 8'h60);
    rc(STATUS_ADDR, 8'h00);
    conv(16'h015E);
    conv(16'h0127);
    rc(STATUS_ADDR, 8'h60);
    conv(16'h015E);
    conv(16'h0126);
    rc(STATUS_ADDR, 8'h20);
    host.xfer(TEMP_MSB_ADDR, 1'b0, 8'h00, q);
    rc(STATUS_ADDR, 8'h80);
    host.xfer(CONFIG_ADDR, 1'b1, 8'h3C, q);
    conv(16'h0096);
    rc(STATUS_ADDR, 8'h00);
    host.xfer(CONFIG_ADDR, 1'b1, 8'h5C, q);
    rc(STATUS_ADDR, 8'h80);
    for (int d = 0; d < 3; d++) begin
      host.xfer(CONFIG_ADDR, 1'b1, {6'h00, d[1:0]}, q);
      conv(16'h0096);
      for (int i = 0; i <= d; i++) begin
        conv(16'h015E);
        chk({7'h00, crit}, {7'h00, i == d});
      end
    end
    @(posedge clk) #1;
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1 rst = 1'b0;
    rc(STATUS_ADDR, 8'h80);
    rc(CONFIG_ADDR, CONFIG_RESET);
    tally_and_finish();
  end
endmodule : test_temp_alarm_status_config
